// [inc/spl_pkg.sv]
// Constants, register map and encodings shared by the position loop gain stage.
package spl_pkg;

    // Parameter addresses on the keypad and serial parameter port.
    localparam logic [15:0] ADDR_KPP     = 16'h0200;
    localparam logic [15:0] ADDR_PFG     = 16'h0202;
    localparam logic [15:0] ADDR_KVP     = 16'h0208;
    localparam logic [15:0] ADDR_TUNE    = 16'h0240;
    localparam logic [15:0] ADDR_BW      = 16'h0242;
    localparam logic [15:0] ADDR_CTRL    = 16'h0244;
    localparam logic [15:0] ADDR_PRESET1 = 16'h0112;
    localparam logic [15:0] ADDR_PRESET2 = 16'h0114;
    localparam logic [15:0] ADDR_PRESET3 = 16'h0116;
    localparam logic [15:0] ADDR_STATUS  = 16'h0246;

    // Reset values.
    localparam logic [15:0] KPP_RST  = 16'h0023;
    localparam logic [15:0] PFG_RST  = 16'h0032;
    localparam logic [15:0] KVP_RST  = 16'h008C;
    localparam logic [15:0] BW_RST   = 16'h0005;
    localparam logic [31:0] PRESET_RST = 32'h0000_0000;

    // Accepted ranges.
    localparam logic [15:0] KPP_MAX  = 16'h07FF;
    localparam logic [15:0] PFG_MAX  = 16'h0064;
    localparam logic [15:0] BW_MIN   = 16'h0001;
    localparam logic [15:0] BW_MAX   = 16'h000A;
    localparam logic [15:0] KV_MAX   = 16'hFFFF;
    localparam logic signed [31:0] SPD_HI = 32'sh0000_C350;
    localparam logic signed [31:0] SPD_LO = -32'sh0000_C350;
    localparam logic signed [49:0] SAT_HI = 50'sh0_0000_0000_C350;
    localparam logic signed [49:0] SAT_LO = -50'sh0_0000_0000_C350;

    // Arithmetic constants.
    localparam logic signed [48:0] FF_DIV       = 49'sh0_0000_0000_0064;
    localparam logic [15:0]        KP_PER_LEVEL = 16'h0014;
    localparam logic signed [32:0] RAMP_STEP    = 33'sh0_0000_0010;

    // Field positions.
    localparam int TUNE_BIT = 0;
    localparam int PDFF_BIT = 0;

    // Control modes of the drive.
    typedef enum logic [1:0] {
        MODE_POS  = 2'b00,
        MODE_SPD  = 2'b01,
        MODE_SPDZ = 2'b10
    } spl_mode_t;

    // Gain tuning modes.
    typedef enum logic {
        TUNE_MANUAL = 1'b0,
        TUNE_AUTO   = 1'b1
    } spl_tune_t;

endpackage

// [rtl/spl_sync.sv]
// Three-stage synchroniser with agreement filter for the speed select inputs.
`timescale 1ns/1ps
module spl_sync
    import spl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [1:0] in_async,
    output logic      [1:0] sync_out
);

    logic [1:0] s1_r;
    logic [1:0] s2_r;
    logic [1:0] s3_r;
    logic [1:0] out_r;
    logic [1:0] out_nxt;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_bit
            // A change is accepted only once the second and third stages agree.
            always_comb begin
                out_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : out_r[gi];
            end

            // The first stage feeds only the second stage.
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_r[gi]  <= 1'b0;
                    s2_r[gi]  <= 1'b0;
                    s3_r[gi]  <= 1'b0;
                    out_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi]  <= in_async[gi];
                    s2_r[gi]  <= s1_r[gi];
                    s3_r[gi]  <= s2_r[gi];
                    out_r[gi] <= out_nxt[gi];
                end
            end
        end
    endgenerate

    assign sync_out = out_r;

endmodule

// [rtl/spl_top.sv]
// Position loop gain stage with speed command source selection and tuning mode.
//
// Behaviour
// R1: Position gain 0..2047, reset 35, used.
// R2: Software keeps speed gain four times position gain.
// R3: Software sets position gain as 2*pi*bandwidth.
// R4: Feed-forward gain 0..100 percent, reset 50.
// R5: Manual tuning uses user gains, no auxiliaries.
// R6: Auto tuning adapts gains from inertia, ten levels.
// R7: Tuning mode register selects manual or auto.
// R8: Speed command from analog input or presets.
// R9: Serial rewrite of a preset drives speed.
// R10: Speed command ramped; PI or PDFF selectable.
// R11: Nonzero select code picks preset on change.
// R12: Code zero: zero command or analog reference.
// R13: Gain times error plus feed-forward, saturated.
`timescale 1ns/1ps
module spl_top
    import spl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        param_wr_en,
    input  wire logic        param_rd_en,
    input  wire logic [15:0] param_addr,
    input  wire logic [31:0] param_wr_data,
    output logic      [31:0] param_rd_data,
    output logic             param_rd_valid,
    input  wire logic [1:0]  control_mode,
    input  wire logic        speed_select_low,
    input  wire logic        speed_select_high,
    input  wire logic [31:0] analog_speed_ref,
    input  wire logic [31:0] position_error,
    input  wire logic [31:0] command_rate,
    input  wire logic [15:0] load_inertia,
    output logic      [31:0] speed_command,
    output logic      [15:0] position_gain,
    output logic      [15:0] velocity_gain,
    output logic             aux_tuning_enable,
    output logic             pdff_select
);

    // Parameter registers.
    logic [15:0]        kpp_r, kpp_nxt;
    logic [15:0]        pfg_r, pfg_nxt;
    logic [15:0]        kvp_r, kvp_nxt;
    logic [15:0]        bw_r, bw_nxt;
    spl_tune_t          tune_r, tune_nxt;
    logic               pdff_r, pdff_nxt;
    logic [31:0]        preset_r [1:3];
    logic [31:0]        preset_nxt [1:3];
    logic [31:0]        rd_r, rd_nxt;
    logic               rdv_r, rdv_nxt;

    // Loop state.
    logic [1:0]         sel_sync;
    logic [1:0]         sel_prev_r, sel_prev_nxt;
    logic [1:0]         sel_idx_r, sel_idx_nxt;
    logic signed [31:0] target_r, target_nxt;
    logic signed [31:0] spd_r, spd_nxt;
    logic [15:0]        kp_eff_r, kp_eff_nxt;
    logic [15:0]        kv_eff_r, kv_eff_nxt;
    logic               aux_r, aux_nxt;

    // Arithmetic temporaries.
    logic signed [48:0] p_term;
    logic signed [48:0] ff_prod;
    logic signed [48:0] ff_term;
    logic signed [49:0] loop_sum;
    logic signed [31:0] loop_sat;
    logic signed [32:0] ramp_diff;
    logic [31:0]        kp_calc;
    logic [32:0]        kv_calc;
    logic signed [31:0] wr_signed;
    logic               preset_ok;

    // Speed select pins arrive asynchronously from the digital inputs.
    spl_sync u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .in_async ({speed_select_high, speed_select_low}),
        .sync_out (sel_sync)
    );

    // Parameter writes; out-of-range values are dropped so the old setting stays.
    always_comb begin
        wr_signed  = $signed(param_wr_data);
        preset_ok  = (wr_signed >= SPD_LO) && (wr_signed <= SPD_HI);
        kpp_nxt    = kpp_r;
        pfg_nxt    = pfg_r;
        kvp_nxt    = kvp_r;
        bw_nxt     = bw_r;
        tune_nxt   = tune_r;
        pdff_nxt   = pdff_r;
        preset_nxt = preset_r;
        if (param_wr_en) begin
            unique case (param_addr)
                ADDR_KPP: if (param_wr_data <= {16'h0000, KPP_MAX}) kpp_nxt = param_wr_data[15:0]; // [R1]
                ADDR_PFG: if (param_wr_data <= {16'h0000, PFG_MAX}) pfg_nxt = param_wr_data[15:0]; // [R4]
                ADDR_KVP: if (param_wr_data[31:16] == 16'h0000) kvp_nxt = param_wr_data[15:0];
                ADDR_BW: begin
                    if ((param_wr_data >= {16'h0000, BW_MIN}) && (param_wr_data <= {16'h0000, BW_MAX})) begin
                        bw_nxt = param_wr_data[15:0]; // [R6]
                    end
                end
                ADDR_TUNE:    tune_nxt = spl_tune_t'(param_wr_data[TUNE_BIT]); // [R7]
                ADDR_CTRL:    pdff_nxt = param_wr_data[PDFF_BIT]; // [R10]
                ADDR_PRESET1: if (preset_ok) preset_nxt[1] = param_wr_data; // [R9]
                ADDR_PRESET2: if (preset_ok) preset_nxt[2] = param_wr_data; // [R9]
                ADDR_PRESET3: if (preset_ok) preset_nxt[3] = param_wr_data; // [R9]
                default: ;
            endcase
        end
    end

    // Parameter reads answer one cycle later; unmapped addresses read zero.
    always_comb begin
        rdv_nxt = param_rd_en;
        rd_nxt  = rd_r;
        if (param_rd_en) begin
            unique case (param_addr)
                ADDR_KPP:     rd_nxt = {16'h0000, kpp_r};
                ADDR_PFG:     rd_nxt = {16'h0000, pfg_r};
                ADDR_KVP:     rd_nxt = {16'h0000, kvp_r};
                ADDR_BW:      rd_nxt = {16'h0000, bw_r};
                ADDR_TUNE:    rd_nxt = {31'h0000_0000, tune_r};
                ADDR_CTRL:    rd_nxt = {31'h0000_0000, pdff_r};
                ADDR_PRESET1: rd_nxt = preset_r[1];
                ADDR_PRESET2: rd_nxt = preset_r[2];
                ADDR_PRESET3: rd_nxt = preset_r[3];
                ADDR_STATUS:  rd_nxt = {kv_eff_r, kp_eff_r};
                default:      rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Gain selection: manual passes the user gains through, auto derives them
    // from the chosen bandwidth level and the measured inertia.
    always_comb begin
        kp_calc = 32'(bw_r) * 32'(KP_PER_LEVEL);
        kv_calc = 33'({kp_eff_r, 2'b00}) + 33'(32'(load_inertia) * 32'(bw_r));
        unique case (tune_r)
            TUNE_MANUAL: begin
                kp_eff_nxt = kpp_r; // [R5]
                kv_eff_nxt = kvp_r; // [R5]
                aux_nxt    = 1'b0; // [R5]
            end
            TUNE_AUTO: begin
                kp_eff_nxt = (kp_calc > 32'(KPP_MAX)) ? KPP_MAX : kp_calc[15:0]; // [R6]
                kv_eff_nxt = (kv_calc > 33'(KV_MAX)) ? KV_MAX : kv_calc[15:0]; // [R6]
                aux_nxt    = 1'b1; // [R6]
            end
        endcase
    end

    // Position loop: proportional term plus feed-forward share of command rate.
    always_comb begin
        p_term   = $signed({1'b0, kp_eff_r}) * $signed(position_error); // [R1]
        ff_prod  = $signed({1'b0, pfg_r}) * $signed(command_rate); // [R4]
        ff_term  = ff_prod / FF_DIV;
        loop_sum = {p_term[48], p_term} + {ff_term[48], ff_term}; // [R13]
        if (loop_sum > SAT_HI) begin
            loop_sat = SPD_HI; // [R13]
        end else if (loop_sum < SAT_LO) begin
            loop_sat = SPD_LO; // [R13]
        end else begin
            loop_sat = loop_sum[31:0];
        end
    end

    // Speed source: the preset index is taken only when a select pin changes,
    // while the preset value itself is read live so serial rewrites act at once.
    always_comb begin
        sel_prev_nxt = sel_sync;
        sel_idx_nxt  = (sel_sync != sel_prev_r) ? sel_sync : sel_idx_r; // [R11]
        unique case (sel_idx_r)
            2'b00:   target_nxt = (control_mode == MODE_SPDZ) ? 32'sh0000_0000
                                                              : $signed(analog_speed_ref); // [R12]
            2'b01:   target_nxt = $signed(preset_r[1]); // [R8]
            2'b10:   target_nxt = $signed(preset_r[2]); // [R8]
            2'b11:   target_nxt = $signed(preset_r[3]); // [R8]
        endcase
    end

    // Command output: position mode follows the loop, speed modes slew toward
    // the target. The linear slew stands in for a full S-curve profile.
    always_comb begin
        ramp_diff = {target_r[31], target_r} - {spd_r[31], spd_r};
        case (control_mode)
            MODE_POS: spd_nxt = loop_sat; // [R1]
            MODE_SPD, MODE_SPDZ: begin
                if (ramp_diff > RAMP_STEP) begin
                    spd_nxt = spd_r + RAMP_STEP[31:0]; // [R10]
                end else if (ramp_diff < -RAMP_STEP) begin
                    spd_nxt = spd_r - RAMP_STEP[31:0]; // [R10]
                end else begin
                    spd_nxt = target_r;
                end
            end
            default: spd_nxt = 32'sh0000_0000;
        endcase
    end

    // All state registers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            kpp_r      <= KPP_RST;
            pfg_r      <= PFG_RST;
            kvp_r      <= KVP_RST;
            bw_r       <= BW_RST;
            tune_r     <= TUNE_MANUAL;
            pdff_r     <= 1'b0;
            preset_r   <= '{PRESET_RST, PRESET_RST, PRESET_RST};
            rd_r       <= 32'h0000_0000;
            rdv_r      <= 1'b0;
            sel_prev_r <= 2'b00;
            sel_idx_r  <= 2'b00;
            target_r   <= 32'sh0000_0000;
            spd_r      <= 32'sh0000_0000;
            kp_eff_r   <= KPP_RST;
            kv_eff_r   <= KVP_RST;
            aux_r      <= 1'b0;
        end else begin
            kpp_r      <= kpp_nxt;
            pfg_r      <= pfg_nxt;
            kvp_r      <= kvp_nxt;
            bw_r       <= bw_nxt;
            tune_r     <= tune_nxt;
            pdff_r     <= pdff_nxt;
            preset_r   <= preset_nxt;
            rd_r       <= rd_nxt;
            rdv_r      <= rdv_nxt;
            sel_prev_r <= sel_prev_nxt;
            sel_idx_r  <= sel_idx_nxt;
            target_r   <= target_nxt;
            spd_r      <= spd_nxt;
            kp_eff_r   <= kp_eff_nxt;
            kv_eff_r   <= kv_eff_nxt;
            aux_r      <= aux_nxt;
        end
    end

    assign param_rd_data     = rd_r;
    assign param_rd_valid    = rdv_r;
    assign speed_command     = spd_r;
    assign position_gain     = kp_eff_r;
    assign velocity_gain     = kv_eff_r;
    assign aux_tuning_enable = aux_r;
    assign pdff_select       = pdff_r;

    // Checks on the gain, tuning and speed source behaviour.
    sequence s_kpp_wr_ok;
        param_wr_en && (param_addr == ADDR_KPP) && (param_wr_data <= 32'h0000_07FF);
    endsequence

    sequence s_sel_change;
        (sel_sync != sel_prev_r) && (sel_sync != 2'b00);
    endsequence

    property p_kpp_reset;
        @(posedge clk) sys_rst |=> (kpp_r == 16'h0023) && (pfg_r == 16'h0032);
    endproperty
    a_kpp_reset: assert property (p_kpp_reset) else $error("gain reset value wrong"); // [R1]

    property p_kpp_write;
        @(posedge clk) disable iff (sys_rst)
        s_kpp_wr_ok ##1 (tune_r == TUNE_MANUAL) |=> (position_gain == $past(param_wr_data[15:0], 2));
    endproperty
    a_kpp_write: assert property (p_kpp_write) else $error("position gain not applied"); // [R1]

    property p_pfg_range;
        @(posedge clk) disable iff (sys_rst)
        (param_wr_en && (param_addr == ADDR_PFG) && (param_wr_data > 32'h0000_0064))
            |=> $stable(pfg_r);
    endproperty
    a_pfg_range: assert property (p_pfg_range) else $error("feed-forward range not kept"); // [R4]

    property p_manual;
        @(posedge clk) disable iff (sys_rst)
        (tune_r == TUNE_MANUAL) |=> !aux_tuning_enable && (position_gain == $past(kpp_r));
    endproperty
    a_manual: assert property (p_manual) else $error("manual tuning not honoured"); // [R5]

    property p_auto;
        @(posedge clk) disable iff (sys_rst)
        (tune_r == TUNE_AUTO) |=> aux_tuning_enable && (position_gain <= 16'h07FF)
            && (position_gain == (($past(bw_r) * 16'h0014 > 16'h07FF) ? 16'h07FF : $past(bw_r) * 16'h0014));
    endproperty
    a_auto: assert property (p_auto) else $error("auto tuning gain wrong"); // [R6]

    property p_tune_write;
        @(posedge clk) disable iff (sys_rst)
        (param_wr_en && (param_addr == ADDR_TUNE)) |=> (tune_r == $past(param_wr_data[0]));
    endproperty
    a_tune_write: assert property (p_tune_write) else $error("tuning mode not stored"); // [R7]

    property p_preset_pick;
        @(posedge clk) disable iff (sys_rst)
        s_sel_change |=> (sel_idx_r == $past(sel_sync)) ##1 (target_r == $signed(preset_r[sel_idx_r]));
    endproperty
    a_preset_pick: assert property (p_preset_pick) else $error("preset not selected"); // [R11]

    property p_zero_cmd;
        @(posedge clk) disable iff (sys_rst)
        (sel_idx_r == 2'b00) && (control_mode == MODE_SPDZ) |=> (target_r == 32'sh0000_0000);
    endproperty
    a_zero_cmd: assert property (p_zero_cmd) else $error("zero command mode not zero"); // [R12]

    property p_ramp;
        @(posedge clk) disable iff (sys_rst)
        (control_mode == MODE_SPD) |=> (($signed(spd_r) - $signed($past(spd_r)) <= 32'sd16)
            && ($signed(spd_r) - $signed($past(spd_r)) >= -32'sd16));
    endproperty
    a_ramp: assert property (p_ramp) else $error("speed step exceeds slew limit"); // [R10]

    property p_sat;
        @(posedge clk) disable iff (sys_rst)
        (control_mode == MODE_POS) |=> ($signed(spd_r) <= 32'sd50000) && ($signed(spd_r) >= -32'sd50000);
    endproperty
    a_sat: assert property (p_sat) else $error("loop output not saturated"); // [R13]

endmodule

// [test/spl_motor_model.sv]
// Behavioural model of the motion controller and motor that face the gain stage.
`timescale 1ns/1ps
module spl_motor_model
    import spl_pkg::*;
#(
    parameter logic [15:0] INERTIA = 16'h0040
)
(
    input  wire logic        clk,
    input  wire logic [1:0]  sel_code,
    input  wire logic [31:0] err_set,
    input  wire logic [31:0] rate_set,
    input  wire logic [31:0] ref_set,
    output logic             speed_select_low,
    output logic             speed_select_high,
    output logic      [31:0] position_error,
    output logic      [31:0] command_rate,
    output logic      [31:0] analog_speed_ref,
    output logic      [15:0] load_inertia
);
    // The controller moves its select pins and feedback just after an edge, as real wiring would.
    initial begin
        speed_select_low  = 1'b0;
        speed_select_high = 1'b0;
        position_error    = '0;
        command_rate      = '0;
        analog_speed_ref  = '0;
        load_inertia      = INERTIA;
    end

    // Select pins carry the preset code; feedback words follow the requested values.
    always @(posedge clk) begin
        speed_select_low  <= sel_code[0];
        speed_select_high <= sel_code[1];
        position_error    <= err_set;
        command_rate      <= rate_set;
        analog_speed_ref  <= ref_set;
        load_inertia      <= INERTIA;
    end
endmodule

// [test/servo_position_loop_gain_tb.sv]
// Self-checking bench for the position loop gain stage.
`timescale 1ns/1ps
module servo_position_loop_gain_tb;
    import spl_pkg::*;

    typedef struct {
        logic [15:0] addr;
        logic [31:0] data;
        logic [31:0] exp;
    } spl_row_t;

    logic        clk;
    logic        sys_rst;
    logic        param_wr_en;
    logic        param_rd_en;
    logic [15:0] param_addr;
    logic [31:0] param_wr_data;
    logic [31:0] param_rd_data;
    logic        param_rd_valid;
    logic [1:0]  control_mode;
    logic        sel_lo;
    logic        sel_hi;
    logic [31:0] ref_w;
    logic [31:0] err_w;
    logic [31:0] rate_w;
    logic [15:0] inertia_w;
    logic [31:0] speed_command;
    logic [15:0] position_gain;
    logic [15:0] velocity_gain;
    logic        aux_tuning_enable;
    logic        pdff_select;
    logic [1:0]  code;
    logic [31:0] err_set;
    logic [31:0] rate_set;
    logic [31:0] ref_set;
    logic [31:0] s0;
    logic [31:0] rd;
    int          err_count;
    int          num_checks;
    spl_row_t    rows [8];

    spl_top spl_top_i (.clk(clk), .sys_rst(sys_rst), .param_wr_en(param_wr_en),
        .param_rd_en(param_rd_en), .param_addr(param_addr), .param_wr_data(param_wr_data),
        .param_rd_data(param_rd_data), .param_rd_valid(param_rd_valid),
        .control_mode(control_mode), .speed_select_low(sel_lo), .speed_select_high(sel_hi),
        .analog_speed_ref(ref_w), .position_error(err_w), .command_rate(rate_w),
        .load_inertia(inertia_w), .speed_command(speed_command),
        .position_gain(position_gain), .velocity_gain(velocity_gain),
        .aux_tuning_enable(aux_tuning_enable), .pdff_select(pdff_select));

    spl_motor_model spl_motor_model_i (.clk(clk), .sel_code(code), .err_set(err_set),
        .rate_set(rate_set), .ref_set(ref_set), .speed_select_low(sel_lo),
        .speed_select_high(sel_hi), .position_error(err_w), .command_rate(rate_w),
        .analog_speed_ref(ref_w), .load_inertia(inertia_w));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Compare one value and count the outcome.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Let n edges pass, then step clear of the edge so outputs have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One-cycle write strobe; the strobe drops at the edge that takes it.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        param_wr_en   <= 1'b1;
        param_addr    <= a;
        param_wr_data <= d;
        @(posedge clk);
        param_wr_en   <= 1'b0;
    endtask

    // One-cycle read strobe; valid and data are taken the cycle after.
    task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk);
        param_rd_en <= 1'b1;
        param_addr  <= a;
        @(posedge clk);
        param_rd_en <= 1'b0;
        #1;
        chk("read valid", {31'h0, param_rd_valid}, 32'h1);
        d = param_rd_data;
    endtask

    // Drive mode and far-side requests together.
    task automatic drive(input logic [1:0] m, input logic [1:0] c, input logic [31:0] e,
                         input logic [31:0] r, input logic [31:0] v);
        @(posedge clk);
        control_mode <= m;
        code         <= c;
        err_set      <= e;
        rate_set     <= r;
        ref_set      <= v;
    endtask

    // A hung run counts as a mismatch.
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    initial begin
        err_count = 0;
        num_checks = 0;
        sys_rst = 1'b1;
        param_wr_en = 1'b0;
        param_rd_en = 1'b0;
        param_addr = 16'h0000;
        param_wr_data = 32'h0;
        control_mode = 2'b00;
        code = 2'b00;
        err_set = 32'h0;
        rate_set = 32'h0;
        ref_set = 32'h0;
        rows[0] = '{ADDR_KPP, 32'h0000_07FF, 32'h0000_07FF};
        rows[1] = '{ADDR_KPP, 32'h0000_0800, 32'h0000_07FF};
        rows[2] = '{ADDR_KPP, 32'h0000_0000, 32'h0000_0000};
        rows[3] = '{ADDR_PFG, 32'h0000_0064, 32'h0000_0064};
        rows[4] = '{ADDR_PFG, 32'h0000_0065, 32'h0000_0064};
        rows[5] = '{16'h0300, 32'h0000_1234, 32'h0000_0000};
        rows[6] = '{ADDR_PRESET1, 32'h0000_C351, 32'h0000_0000};
        rows[7] = '{ADDR_PRESET1, 32'hFFFF_3CB0, 32'hFFFF_3CB0};
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        tick(1);
        chk("gain at reset", {16'h0, position_gain}, 32'h0000_0023);
        chk("aux at reset", {31'h0, aux_tuning_enable}, 32'h0);
        rd_reg(ADDR_KPP, rd);
        chk("position gain reset", rd, 32'h0000_0023);
        rd_reg(ADDR_PFG, rd);
        chk("feed forward reset", rd, 32'h0000_0032);
        // Table of writes, each read back through the parameter port.
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].data);
            rd_reg(rows[i].addr, rd);
            chk("table readback", rd, rows[i].exp);
        end
        // Loop output: gain 10, feed-forward 50 percent, then saturation both ways.
        wr(ADDR_KPP, 32'h0000_000A);
        wr(ADDR_PFG, 32'h0000_0032);
        drive(2'b00, 2'b00, 32'd100, 32'd200, 32'h0);
        tick(5);
        chk("loop output", speed_command, 32'd1100);
        drive(2'b00, 2'b00, -32'sd100, -32'sd200, 32'h0);
        tick(5);
        chk("loop output neg", speed_command, -32'sd1100);
        drive(2'b00, 2'b00, 32'd100000, 32'd0, 32'h0);
        tick(5);
        chk("loop saturate hi", speed_command, 32'd50000);
        drive(2'b00, 2'b00, -32'sd100000, 32'd0, 32'h0);
        tick(5);
        chk("loop saturate lo", speed_command, 32'hFFFF_3CB0);
        // Configure for 20 Hz: gain 125, speed gain kept at least four times larger.
        wr(ADDR_KPP, 32'd125);
        wr(ADDR_KVP, 32'd500);
        tick(4);
        chk("manual gain", {16'h0, position_gain}, 32'd125);
        chk("manual speed gain", {16'h0, velocity_gain}, 32'd500);
        // Auto tuning: gain follows the bandwidth level, not the user value.
        wr(ADDR_TUNE, 32'h1);
        tick(4);
        chk("auto aux", {31'h0, aux_tuning_enable}, 32'h1);
        chk("auto gain lvl5", {16'h0, position_gain}, 32'd100);
        wr(ADDR_BW, 32'd10);
        wr(ADDR_BW, 32'd11);
        tick(4);
        chk("auto gain lvl10", {16'h0, position_gain}, 32'd200);
        chk("auto speed gain", {16'h0, velocity_gain}, 32'd1440);
        wr(ADDR_TUNE, 32'h0);
        tick(4);
        chk("back to manual", {16'h0, position_gain}, 32'd125);
        chk("manual aux", {31'h0, aux_tuning_enable}, 32'h0);
        // Speed modes: analog reference, then forced zero with both selects idle.
        // The command starts from the negative limit, so the slew needs over 3175 cycles.
        drive(2'b01, 2'b00, 32'h0, 32'h0, 32'd800);
        tick(3300);
        chk("analog source", speed_command, 32'd800);
        drive(2'b10, 2'b00, 32'h0, 32'h0, 32'd800);
        tick(80);
        chk("zero source", speed_command, 32'h0);
        wr(ADDR_PRESET1, 32'd480);
        wr(ADDR_PRESET2, -32'sd480);
        wr(ADDR_PRESET3, 32'd960);
        drive(2'b10, 2'b01, 32'h0, 32'h0, 32'd800);
        tick(12);
        s0 = speed_command;
        tick(1);
        chk("slew step", speed_command - s0, 32'd16);
        tick(60);
        chk("preset one", speed_command, 32'd480);
        drive(2'b01, 2'b10, 32'h0, 32'h0, 32'd800);
        tick(100);
        chk("preset two", speed_command, -32'sd480);
        drive(2'b01, 2'b11, 32'h0, 32'h0, 32'd800);
        tick(120);
        chk("preset three", speed_command, 32'd960);
        wr(ADDR_PRESET3, 32'd320);
        tick(60);
        chk("preset rewrite", speed_command, 32'd320);
        wr(ADDR_CTRL, 32'h1);
        tick(3);
        chk("pdff select", {31'h0, pdff_select}, 32'h1);
        // Second reset in mid-run restores the defaults; position mode with no error
        // keeps the command at zero once the reset is released.
        drive(2'b00, 2'b00, 32'h0, 32'h0, 32'h0);
        tick(3);
        @(posedge clk);
        sys_rst <= 1'b1;
        tick(2);
        @(posedge clk);
        sys_rst <= 1'b0;
        tick(2);
        chk("gain after reset", {16'h0, position_gain}, 32'h0000_0023);
        chk("speed after reset", speed_command, 32'h0);
        wrap_up();
    end
endmodule
